// [verilog/clkbuf_cfg_map.svh]
// Offsets, field positions, reset values and masks of the clock buffer register bank
`ifndef CLKBUF_CFG_MAP_SVH
`define CLKBUF_CFG_MAP_SVH
`define BUS_TARGET_ADDR 7'h6D
`define OFS_OUTPUT_ENABLE 3'h0
`define OFS_MODE_CONTROL 3'h1
`define OFS_OUTPUT_SLEW 3'h2
`define OFS_FREQ_SELECT 3'h3
`define OFS_RESERVED 3'h4
`define OFS_REV_VENDOR 3'h5
`define OFS_TYPE_ID 3'h6
`define OFS_READ_LENGTH 3'h7
`define BIT_SECOND_ENABLE 5
`define BIT_FIRST_ENABLE 3
`define BIT_MODE_SOURCE 5
`define BIT_SECOND_EDGE 5
`define BIT_FIRST_EDGE 3
`define BIT_FREQ_SW_EN 5
`define BIT_FEEDBACK_EDGE 0
`define RST_OUTPUT_ENABLE 8'hFF
`define RST_MODE_CONTROL 8'h06
`define RST_OUTPUT_SLEW 8'hFF
`define RST_FREQ_SELECT 8'hC7
`define RST_RESERVED 8'hFF
`define RST_READ_LENGTH 8'h08
`define MSK_OUTPUT_ENABLE 8'h28
`define MSK_MODE_CONTROL 8'h3B
`define MSK_OUTPUT_SLEW 8'h28
`define MSK_FREQ_SELECT 8'h39
`define MSK_READ_LENGTH 8'h1F
`define TYPE_ZERO_DELAY 2'h1
`endif

// [verilog/clkbuf_cfg_pkg.sv]
// Types shared by the clock buffer register bank
`default_nettype none
package clkbuf_cfg_pkg;
	typedef enum logic [2:0] {
		st_idle, st_addr, st_cmd, st_wcnt, st_wdata, st_rdata
	} bus_state_t;
	typedef struct packed {
		logic first_run;
		logic second_run;
		logic first_fast;
		logic second_fast;
		logic feedback_fast;
		logic [1:0] operating_mode;
		logic freq_sw_active;
		logic [1:0] frequency_code;
	} cfg_t;
endpackage
`default_nettype wire

// [verilog/clock_buffer_config_regs.sv]
// Serial-bus register bank of a two-output clock buffer
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_cfg_map.svh"
//
// Overview of operation
// (RL1) A cleared output enable bit forces that pair low, overriding the enable pin.
// (RL2) Software mode and frequency bits act only while mode-source bit is one.
// (RL3) Second output edge bit: read/write, powers up one, one means fast.
// (RL4) First output edge bit: read/write, powers up one, one means fast.
// (RL5) Software frequency enable bit: read/write, powers up zero, one enables.
// (RL6) Two-bit read/write frequency code powers up as zero.
// (RL7) Feedback edge bit: read/write, powers up one, one selects faster edge.
// (RL8) Revision and vendor byte is read-only and fixed.
// (RL9) Type and identifier byte is read-only; type field says zero-delay buffer.
// (RL10) Read length field sets block read length, defaults eight, upper bits zero.
// (RL11) Device is a target only and answers its one fixed address.
// (RL12) Block write: index, count, data; block read: index, restart, count, data.
// (RL13) Host may stop after any byte; finished bytes stay, bus is released.
// (RL14) Mode-source bit picks strap readback at zero, software mode at one.
// (RL15) Writes to reserved and read-only bits are ignored; they read power-up values.
module clock_buffer_config_regs
	import clkbuf_cfg_pkg::*;
#(
	parameter logic [3:0] REVISION = 4'h1,
	parameter logic [3:0] VENDOR = 4'h5,
	parameter logic [5:0] PART_ID = 6'h15
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic first_enable_n,
	input wire logic second_enable_n,
	input wire logic [1:0] strap_mode,
	output cfg_t cfg
);
	// Revision, vendor and identifier values are arbitrary
	// (RL8) fixed revision vendor
	localparam logic [7:0] REV_VENDOR = {REVISION, VENDOR};
	// (RL9) fixed type identifier
	localparam logic [7:0] TYPE_ID = {`TYPE_ZERO_DELAY, PART_ID};

	////////////////////////////////////////////////////////////////////////////////
	// Bus line edges

	logic scl_q, sda_q;
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire start_seen = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_seen = scl_in & scl_q & ~sda_q & sda_in;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage and decode

	logic [7:0] bank_reg [0:7];
	logic [1:0] strap_reg;
	logic strap_taken_reg;
	logic [7:0] index_reg;
	logic [7:0] rx_reg, tx_reg;
	logic [7:0] wr_left_reg, rd_left_reg;
	logic [3:0] bit_reg;
	bus_state_t state_reg;

	wire in_range = (index_reg[7:3] == 5'h0);
	wire [2:0] idx = index_reg[2:0];
	wire [7:0] wmask = (idx == `OFS_OUTPUT_ENABLE) ? `MSK_OUTPUT_ENABLE :
		(idx == `OFS_MODE_CONTROL) ? `MSK_MODE_CONTROL :
		(idx == `OFS_OUTPUT_SLEW) ? `MSK_OUTPUT_SLEW :
		(idx == `OFS_FREQ_SELECT) ? `MSK_FREQ_SELECT :
		(idx == `OFS_READ_LENGTH) ? `MSK_READ_LENGTH : 8'h00;
	wire [7:0] rd_byte = !in_range ? 8'h00 :
		(idx == `OFS_MODE_CONTROL) ? {strap_reg, bank_reg[idx][5:0]} : bank_reg[idx];
	wire byte_done = scl_fall && bit_reg == 4'h7;
	wire ack_done = scl_fall && bit_reg == 4'h8;
	wire addr_hit = rx_reg[7:1] == `BUS_TARGET_ADDR;
	wire write_now = byte_done && state_reg == st_wdata && wr_left_reg != 8'h00;
	wire [7:0] write_val = (rx_reg & wmask) | (bank_reg[idx] & ~wmask);

	// Ignored write bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bank_reg[0] <= `RST_OUTPUT_ENABLE;
			bank_reg[1] <= `RST_MODE_CONTROL;
			bank_reg[2] <= `RST_OUTPUT_SLEW;
			bank_reg[3] <= `RST_FREQ_SELECT;
			bank_reg[4] <= `RST_RESERVED;
			bank_reg[5] <= REV_VENDOR;
			bank_reg[6] <= TYPE_ID;
			bank_reg[7] <= `RST_READ_LENGTH;
		end else if (write_now && in_range) begin
			// (RL15) masked write
			bank_reg[idx] <= write_val;
		end
	end

	// Strap level caught after release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_reg <= 2'h0;
			strap_taken_reg <= 1'b0;
		end else if (!strap_taken_reg) begin
			strap_reg <= strap_mode;
			strap_taken_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus target engine

	wire tx_mode = state_reg == st_rdata;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= st_idle;
			bit_reg <= 4'h0;
			rx_reg <= 8'h00;
			tx_reg <= 8'hFF;
			index_reg <= 8'h00;
			wr_left_reg <= 8'h00;
			rd_left_reg <= 8'h00;
			sda_oe <= 1'b0;
		end else if (start_seen) begin
			state_reg <= st_addr;
			bit_reg <= 4'hF;
			sda_oe <= 1'b0;
		end else if (stop_seen) begin
			// (RL13) release on stop
			state_reg <= st_idle;
			sda_oe <= 1'b0;
		end else if (state_reg == st_idle) begin
			sda_oe <= 1'b0;
		end else if (scl_fall && bit_reg == 4'hF) begin
			// Hold fall after start is no bit
			bit_reg <= 4'h0;
		end else if (scl_rise && bit_reg < 4'h8 && !tx_mode) begin
			rx_reg <= {rx_reg[6:0], sda_in};
		end else if (scl_rise && bit_reg == 4'h8 && tx_mode) begin
			// (RL13) host refusal ends read
			if (sda_in) begin
				state_reg <= st_idle;
			end else if (rd_left_reg == 8'h00) begin
				tx_reg <= 8'hFF;
			end else begin
				tx_reg <= rd_byte;
				index_reg <= index_reg + 8'h01;
				rd_left_reg <= rd_left_reg - 8'h01;
			end
		end else if (byte_done) begin
			bit_reg <= 4'h8;
			sda_oe <= !tx_mode && (state_reg != st_addr || addr_hit);
			unique case (state_reg)
				// (RL11) address match
				st_addr: begin
					if (!addr_hit) begin
						state_reg <= st_idle;
					end else if (rx_reg[0]) begin
						// (RL12) count leads read
						// (RL10) programmed read length
						tx_reg <= {3'h0, bank_reg[`OFS_READ_LENGTH][4:0]};
						rd_left_reg <= {3'h0, bank_reg[`OFS_READ_LENGTH][4:0]};
					end else begin
						state_reg <= st_cmd;
					end
				end
				st_cmd: begin
					index_reg <= rx_reg;
					state_reg <= st_wcnt;
				end
				st_wcnt: begin
					wr_left_reg <= rx_reg;
					state_reg <= st_wdata;
				end
				st_wdata: begin
					// (RL12) consecutive data bytes
					if (wr_left_reg != 8'h00) begin
						index_reg <= index_reg + 8'h01;
						wr_left_reg <= wr_left_reg - 8'h01;
					end
				end
				st_rdata: begin
				end
			endcase
		end else if (ack_done) begin
			bit_reg <= 4'h0;
			sda_oe <= (tx_mode || state_reg == st_addr) && !tx_reg[7];
			// Read starts once address ack ends
			if (state_reg == st_addr) begin
				state_reg <= st_rdata;
			end
		end else if (scl_fall && bit_reg < 4'h7) begin
			bit_reg <= bit_reg + 4'h1;
			if (tx_mode) begin
				tx_reg <= {tx_reg[6:0], 1'b1};
				sda_oe <= !tx_reg[6];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration outputs

	wire sw_mode = bank_reg[`OFS_MODE_CONTROL][`BIT_MODE_SOURCE];
	wire freq_sw = bank_reg[`OFS_FREQ_SELECT][`BIT_FREQ_SW_EN];
	cfg_t cfg_next;

	always_comb begin
		// (RL1) enable bit over pin
		cfg_next.first_run = bank_reg[`OFS_OUTPUT_ENABLE][`BIT_FIRST_ENABLE] & ~first_enable_n;
		cfg_next.second_run = bank_reg[`OFS_OUTPUT_ENABLE][`BIT_SECOND_ENABLE] & ~second_enable_n;
		// (RL4) first edge speed
		cfg_next.first_fast = bank_reg[`OFS_OUTPUT_SLEW][`BIT_FIRST_EDGE];
		// (RL3) second edge speed
		cfg_next.second_fast = bank_reg[`OFS_OUTPUT_SLEW][`BIT_SECOND_EDGE];
		// (RL7) feedback edge speed
		cfg_next.feedback_fast = bank_reg[`OFS_FREQ_SELECT][`BIT_FEEDBACK_EDGE];
		// (RL14) mode source select
		cfg_next.operating_mode = sw_mode ? bank_reg[`OFS_MODE_CONTROL][4:3] : strap_reg;
		// (RL2) gated software frequency
		cfg_next.freq_sw_active = sw_mode & freq_sw;
		// (RL5) (RL6) frequency code
		cfg_next.frequency_code = (sw_mode & freq_sw) ? bank_reg[`OFS_FREQ_SELECT][4:3] : 2'h0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= '0;
		end else begin
			cfg <= cfg_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_first_forced;
		@(posedge clk) disable iff (!rstn)
		!bank_reg[0][`BIT_FIRST_ENABLE] |=> !cfg.first_run;
	endproperty
	a_first_forced: assert property (p_first_forced) else $error("first pair not forced low"); // RL1

	property p_sw_ignored;
		@(posedge clk) disable iff (!rstn)
		!sw_mode |=> (cfg.operating_mode == $past(strap_reg)) && !cfg.freq_sw_active;
	endproperty
	a_sw_ignored: assert property (p_sw_ignored) else $error("software bits acted while off"); // RL2

	property p_second_edge;
		@(posedge clk) disable iff (!rstn)
		write_now && idx == `OFS_OUTPUT_SLEW ##2 1 |-> cfg.second_fast == $past(rx_reg[5], 2);
	endproperty
	a_second_edge: assert property (p_second_edge) else $error("second edge bit lost"); // RL3

	property p_first_edge;
		@(posedge clk) disable iff (!rstn)
		write_now && idx == `OFS_OUTPUT_SLEW ##2 1 |-> cfg.first_fast == $past(rx_reg[3], 2);
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("first edge bit lost"); // RL4

	property p_freq_code;
		@(posedge clk) disable iff (!rstn)
		sw_mode && freq_sw |=> cfg.frequency_code == $past(bank_reg[3][4:3]);
	endproperty
	a_freq_code: assert property (p_freq_code) else $error("frequency code not applied"); // RL6

	property p_feedback;
		@(posedge clk) disable iff (!rstn)
		$changed(bank_reg[3][0]) |=> cfg.feedback_fast == $past(bank_reg[3][0]);
	endproperty
	a_feedback: assert property (p_feedback) else $error("feedback edge not followed"); // RL7

	property p_fixed_ids;
		@(posedge clk) disable iff (!rstn)
		bank_reg[5] == REV_VENDOR && bank_reg[6] == TYPE_ID && bank_reg[4] == `RST_RESERVED;
	endproperty
	a_fixed_ids: assert property (p_fixed_ids) else $error("read-only byte changed"); // RL8

	property p_type_read;
		@(posedge clk) disable iff (!rstn)
		index_reg == 8'h06 |-> rd_byte[7:6] == `TYPE_ZERO_DELAY;
	endproperty
	a_type_read: assert property (p_type_read) else $error("type field wrong"); // RL9

	property p_length_top;
		@(posedge clk) disable iff (!rstn)
		bank_reg[7][7:5] == 3'h0;
	endproperty
	a_length_top: assert property (p_length_top) else $error("length upper bits set"); // RL10

	property p_no_foreign_ack;
		@(posedge clk) disable iff (!rstn)
		byte_done && state_reg == st_addr && !addr_hit |=> !sda_oe && state_reg == st_idle;
	endproperty
	a_no_foreign_ack: assert property (p_no_foreign_ack) else $error("acked foreign address"); // RL11

	property p_stop_release;
		@(posedge clk) disable iff (!rstn)
		stop_seen && !start_seen |=> !sda_oe ##1 !sda_oe;
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("bus held after stop"); // RL13

	property p_mask_write;
		@(posedge clk) disable iff (!rstn)
		write_now && in_range |=> (bank_reg[$past(idx)] & ~$past(wmask)) ==
			($past(bank_reg[idx]) & ~$past(wmask));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("protected bits written"); // RL15

endmodule
`default_nettype wire

// [verif/smbus_host_model.sv]
// Two-wire bus host model driving clock and data toward the register bank
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic hdrv = 1'b1;
	logic sdrv = 1'b1;
	// Open drain line with pull-up
	assign sda = hdrv & ~sda_oe;
	assign scl = sdrv;
	////////////////////////////////////////////////////////////////
	task automatic put(input logic s, input logic d);
		sdrv <= s;
		hdrv <= d;
		repeat (5) @(posedge clk);
	endtask
	task automatic start();
		put(1'b0, 1'b1);
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
		put(1'b0, 1'b0);
	endtask
	task automatic stop();
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			put(1'b0, b[i]);
			put(1'b1, b[i]);
		end
		put(1'b0, 1'b1);
		put(1'b1, 1'b1);
		ack = ~sda;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			put(1'b0, 1'b1);
			put(1'b1, 1'b1);
			b = {b[6:0], sda};
		end
		put(1'b0, nack);
		put(1'b1, nack);
	endtask
endmodule
`default_nettype wire

// [verif/tb_clock_buffer_config_regs.sv]
// Self-checking bench for the clock buffer register bank
`timescale 1ns/1ps
`default_nettype none
module tb_clock_buffer_config_regs
	import clkbuf_cfg_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic fen_n = 1'b0;
	logic sen_n = 1'b0;
	logic [1:0] strap = 2'h2;
	logic nak;
	wire logic scl, sda, sda_out, sda_oe;
	cfg_t cfg_w;
	int err_total = 0;
	int checks = 0;
	integer seed = 32'hB910CA4C;
	logic [7:0] mem [8];
	always #4 clk = ~clk;
	clock_buffer_config_regs uut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .first_enable_n(fen_n),
		.second_enable_n(sen_n), .strap_mode(strap), .cfg(cfg_w));
	smbus_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] msk(input logic [2:0] k);
		case (k)
			3'h0, 3'h2: return 8'h28;
			3'h1: return 8'h3B;
			3'h3: return 8'h39;
			3'h7: return 8'h1F;
			default: return 8'h00;
		endcase
	endfunction
	function automatic cfg_t ecfg();
		cfg_t c;
		logic act;
		act = mem[1][5] & mem[3][5];
		c.first_run = mem[0][3] & ~fen_n;
		c.second_run = mem[0][5] & ~sen_n;
		c.first_fast = mem[2][3];
		c.second_fast = mem[2][5];
		c.feedback_fast = mem[3][0];
		c.operating_mode = mem[1][5] ? mem[1][4:3] : strap;
		c.freq_sw_active = act;
		c.frequency_code = act ? mem[3][4:3] : 2'h0;
		return c;
	endfunction
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task automatic wr(input logic [2:0] i0, input int n, input logic [7:0] cnt,
		input logic [8:0] fd);
		logic a;
		logic [7:0] d;
		logic [2:0] k;
		host.start();
		host.wbyte(8'hDA, a);
		chk("addr ack", 10'h1, 10'(a));
		host.wbyte({5'h0, i0}, a);
		host.wbyte(cnt, a);
		for (int j = 0; j < n; j++) begin
			d = fd[8] ? fd[7:0] : 8'($random(seed));
			host.wbyte(d, a);
			k = i0 + 3'(j);
			mem[k] = (mem[k] & ~msk(k)) | (d & msk(k));
		end
		host.stop();
	endtask
	task automatic rd(input logic [2:0] i0, input int n);
		logic a;
		logic [7:0] d, e;
		host.start();
		host.wbyte(8'hDA, a);
		host.wbyte({5'h0, i0}, a);
		host.start();
		host.wbyte(8'hDB, a);
		host.rbyte(1'b0, d);
		chk("count", 10'(mem[7]), 10'(d));
		for (int j = 0; j < n; j++) begin
			host.rbyte(j == n - 1, d);
			e = (j >= mem[7]) ? 8'hFF : (i0 + j > 7) ? 8'h00 : mem[i0 + j];
			chk("read byte", 10'(e), 10'(d));
		end
		host.stop();
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		err_total++;
		end_of_test();
	end
	initial begin
		mem = '{8'hFF, 8'h86, 8'hFF, 8'hC7, 8'hFF, 8'h15, 8'h55, 8'h08};
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(3'h0, 8);
		chk("cfg", 10'(ecfg()), 10'(cfg_w));
		chk("sda_out", 10'h0, 10'(sda_out));
		$display("test reset values done");
		for (int r = 0; r < 5; r++) begin
			fen_n <= 1'($random(seed));
			sen_n <= 1'($random(seed));
			wr(3'h0, 8, 8'h08, 9'h0);
			rd(3'h0, 8);
			chk("cfg", 10'(ecfg()), 10'(cfg_w));
		end
		$display("test random writes done");
		wr(3'h1, 3, 8'h03, 9'h13B);
		chk("cfg", 10'(ecfg()), 10'(cfg_w));
		wr(3'h1, 1, 8'h01, 9'h11B);
		chk("cfg", 10'(ecfg()), 10'(cfg_w));
		wr(3'h2, 1, 8'h03, 9'h100);
		rd(3'h2, 2);
		$display("test mode source and early stop done");
		wr(3'h7, 1, 8'h01, 9'h1E3);
		rd(3'h5, 4);
		wr(3'h7, 1, 8'h01, 9'h108);
		rd(3'h6, 3);
		$display("test read length done");
		strap <= 2'h1;
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		chk("reset cfg", 10'h0, 10'(cfg_w));
		rstn <= 1'b1;
		mem = '{8'hFF, 8'h46, 8'hFF, 8'hC7, 8'hFF, 8'h15, 8'h55, 8'h08};
		repeat (4) @(posedge clk);
		rd(3'h0, 8);
		chk("cfg", 10'(ecfg()), 10'(cfg_w));
		$display("test second reset done");
		host.start();
		host.wbyte(8'hB4, nak);
		chk("foreign ack", 10'h0, 10'(nak));
		host.stop();
		rd(3'h3, 1);
		$display("test foreign address done");
		end_of_test();
	end
endmodule
`default_nettype wire
